//--- rtl/power_flags_pkg.sv
// Package for the power event flag register bank
package power_flags_pkg;

    // Register byte offsets
    localparam logic [11:0] FLAGS_OFFSET = 12'h000;
    localparam logic [11:0] MASK_OFFSET = 12'h004;
    localparam logic [11:0] CTRL_OFFSET = 12'h008;

    // Flag bit positions
    localparam int DEEP_SLEEP_EXIT_BIT = 15;
    localparam int CORE_TRIP_BIT = 13;
    localparam int IO_TRIP_BIT = 12;
    localparam int SOFT_POR_BIT = 10;
    localparam int RESET_PIN_BIT = 9;
    localparam int SOFT_BOR_BIT = 8;
    localparam int IO_LEVEL_BIT = 6;
    localparam int IO_MONITOR_BIT = 5;
    localparam int IO_DELAY_BIT = 4;
    localparam int CORE_LEVEL_BIT = 2;
    localparam int CORE_MONITOR_BIT = 1;
    localparam int CORE_DELAY_BIT = 0;

    // Control register bit positions
    localparam int IO_RESET_EN_BIT = 1;
    localparam int CORE_RESET_EN_BIT = 0;

    // Implemented flag bits; 14, 11, 7 and 3 are absent
    localparam logic [15:0] FLAGS_WRITABLE = 16'hB777;
    // Flags cleared by a reset vector word read
    localparam logic [15:0] RESET_VEC_CLEAR = 16'hB700;
    // Flags cleared by an interrupt vector word read
    localparam logic [15:0] INT_VEC_CLEAR = 16'h0011;
    // Flags whose vector source follows a reset enable
    localparam logic [15:0] LEVEL_FLAGS = 16'h0044;
    // Supervisor trip flags loaded at power-up
    localparam logic [15:0] TRIP_FLAGS = 16'h3000;
    // Reset values
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Hardware event inputs, one pulse per event
    typedef struct packed {
        logic deep_sleep_exit;
        logic core_trip;
        logic io_trip;
        logic soft_por;
        logic reset_pin;
        logic soft_bor;
        logic io_level;
        logic io_monitor;
        logic io_delay;
        logic core_level;
        logic core_monitor;
        logic core_delay;
    } power_events_t;

    // Map events onto flag layout
    function automatic logic [15:0] event_vector(input power_events_t ev);
        logic [15:0] v;
        v = 16'h0000;
        v[DEEP_SLEEP_EXIT_BIT] = ev.deep_sleep_exit;
        v[CORE_TRIP_BIT] = ev.core_trip;
        v[IO_TRIP_BIT] = ev.io_trip;
        v[SOFT_POR_BIT] = ev.soft_por;
        v[RESET_PIN_BIT] = ev.reset_pin;
        v[SOFT_BOR_BIT] = ev.soft_bor;
        v[IO_LEVEL_BIT] = ev.io_level;
        v[IO_MONITOR_BIT] = ev.io_monitor;
        v[IO_DELAY_BIT] = ev.io_delay;
        v[CORE_LEVEL_BIT] = ev.core_level;
        v[CORE_MONITOR_BIT] = ev.core_monitor;
        v[CORE_DELAY_BIT] = ev.core_delay;
        return v;
    endfunction : event_vector

endpackage : power_flags_pkg

//--- rtl/power_event_flags.sv
// Power event flag register bank with APB slave and interrupt
`timescale 1ns/1ns
// Behaviour
// - Deep-sleep exit sets bit 15; sw/reset-vector clear
// - Io supply power failure clears bit 15
// - Bit 13 cleared by sw or reset-vector read
// - Bit 12 cleared by sw or reset-vector read
// - Soft power-on reset sets bit 10
// - Reset pin sets bit 9
// - Soft brownout request sets bit 8
// - Bit 6 vector clear follows io reset enable
// - Bit 5 cleared only by software write or power-up load
// - Io delay expiry sets bit 4; int-vector clears
// - Bit 2 vector clear follows core reset enable
// - Bit 1 cleared only by software write or power-up load
// - Core delay expiry sets bit 0; int-vector clears
// - Bits 14, 11, 7, 3 read zero
// - One bit per flag, 1 means pending
// - Bits 13,12,6,2 start from power-up values
// - Io reset enable turns io drop into reset
// - Core reset enable turns core drop into reset
module power_event_flags
    import power_flags_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supervisor events and vector reads
    input wire power_events_t events,
    input wire logic io_supply_fail,
    input wire logic reset_vector_read,
    input wire logic int_vector_read,
    input wire logic power_up_init,
    input wire logic [15:0] power_up_flags,
    input wire logic core_supply_low,
    input wire logic io_supply_low,
    // Results
    output logic power_on_reset_req,
    output logic irq
);

    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] flags_load;
    logic [15:0] mask_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic por_reg;
    logic [15:0] set_vec;
    logic [15:0] vec_clear;
    logic [15:0] byte_mask;
    logic access;
    logic wr_en;

    // Register address decode
    function automatic logic [1:0] decode(input logic [11:0] addr);
        case (addr)
            FLAGS_OFFSET: decode = 2'h1;
            MASK_OFFSET: decode = 2'h2;
            CTRL_OFFSET: decode = 2'h3;
            default: decode = 2'h0;
        endcase
    endfunction : decode

    assign access = psel && penable && !pready_reg;
    assign wr_en = access && pwrite && (decode(paddr) != 2'h0);
    assign byte_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign set_vec = event_vector(events);

    // Vector read clear sources per flag
    always_comb begin
        vec_clear = 16'h0000;
        if (reset_vector_read) begin
            vec_clear = RESET_VEC_CLEAR;
        end
        if (int_vector_read) begin
            vec_clear = vec_clear | INT_VEC_CLEAR;
        end
        vec_clear[IO_LEVEL_BIT] = ctrl_reg[IO_RESET_EN_BIT] ? reset_vector_read
                                                            : int_vector_read;
        vec_clear[CORE_LEVEL_BIT] = ctrl_reg[CORE_RESET_EN_BIT] ? reset_vector_read
                                                                : int_vector_read;
        vec_clear[IO_MONITOR_BIT] = 1'b0;
        vec_clear[CORE_MONITOR_BIT] = 1'b0;
    end

    // Next flag value: write, then clears, then sets win
    always_comb begin
        flags_next = flags_reg;
        if (wr_en && decode(paddr) == 2'h1) begin
            flags_next = (flags_reg & ~byte_mask)
                       | (pwdata[15:0] & byte_mask);
        end
        flags_next = flags_next & ~vec_clear;
        if (io_supply_fail) begin
            flags_next[DEEP_SLEEP_EXIT_BIT] = 1'b0;
        end
        flags_next = (flags_next | set_vec) & FLAGS_WRITABLE;
    end

    // Power-up load overrides; irq follows the same value so it is not a cycle late
    always_comb begin
        flags_load = flags_next;
        if (power_up_init) begin
            flags_load = power_up_flags & (LEVEL_FLAGS | TRIP_FLAGS);
        end
    end

    // Flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_load;
        end
    end

    // Mask and control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= MASK_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en) begin
            if (decode(paddr) == 2'h2) begin
                mask_reg <= ((mask_reg & ~byte_mask) | (pwdata[15:0] & byte_mask))
                          & FLAGS_WRITABLE;
            end
            if (decode(paddr) == 2'h3 && pstrb[0]) begin
                ctrl_reg <= pwdata[1:0];
            end
        end
    end

    // APB answer: one wait state, reads are registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access;
            pslverr_reg <= access && (decode(paddr) == 2'h0);
            prdata_reg <= 32'h0000_0000;
            if (access && !pwrite) begin
                case (decode(paddr))
                    2'h1: prdata_reg <= {16'h0000, flags_reg & FLAGS_WRITABLE};
                    2'h2: prdata_reg <= {16'h0000, mask_reg};
                    2'h3: prdata_reg <= {30'h0, ctrl_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Interrupt and power-on reset request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
            por_reg <= 1'b0;
        end else begin
            irq_reg <= |(flags_load & mask_reg);
            por_reg <= (io_supply_low && ctrl_reg[IO_RESET_EN_BIT])
                     || (core_supply_low && ctrl_reg[CORE_RESET_EN_BIT]);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign power_on_reset_req = por_reg;

endmodule : power_event_flags

//--- dv/power_event_flags_asserts.sv
// Checker for the power event flag bank
`timescale 1ns/1ns
module power_event_flags_asserts
    import power_flags_pkg::*;
(
    // Bus
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready, pslverr,
    // Events and results
    input wire power_events_t events,
    input wire logic power_up_init, core_supply_low, io_supply_low,
    input wire logic power_on_reset_req, irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Causes of a new interrupt, decoded addresses
    logic cause;
    logic mapped;
    assign cause = |events || power_up_init || (psel && pwrite);
    assign mapped = paddr inside {FLAGS_OFFSET, MASK_OFFSET, CTRL_OFFSET};
    sequence s_acc; psel && penable && !pready; endsequence
    sequence s_rd; pready && !pwrite; endsequence
    property p_wait; s_acc |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_held; pready |-> psel && penable; endproperty
    a_held: assert property (p_held) else $error("ready outside access");
    property p_err; pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_err: assert property (p_err) else $error("unmapped answer");
    property p_ok; pready && mapped |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("false error");
    property p_rsvd; s_rd ##0 (paddr == FLAGS_OFFSET) |-> (prdata & 32'hFFFF4888) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("unused bit set");
    property p_por; power_on_reset_req |-> $past(io_supply_low) || $past(core_supply_low);
    endproperty
    a_por: assert property (p_por) else $error("reset without low supply");
    property p_irq; $rose(irq) |-> $past(cause); endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : power_event_flags_asserts

bind power_event_flags power_event_flags_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .power_up_init(power_up_init),
    .core_supply_low(core_supply_low), .io_supply_low(io_supply_low),
    .power_on_reset_req(power_on_reset_req), .irq(irq));

//--- dv/power_event_flags_tb.sv
// Self-checking bench for the power event flag bank
`timescale 1ns/1ns
module power_event_flags_tb import power_flags_pkg::*;;
    typedef struct { logic [1:0] ctrl; logic [15:0] vec; logic [15:0] exp; } row_t;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'h3;
    logic pready, pslverr, er, por, irq;
    power_events_t events = '0;
    logic io_supply_fail = '0, rvr = '0, ivr = '0, pu = '0, core_low = '0, io_low = '0;
    logic [15:0] pu_flags = '0;
    int errors = 0, n_compared = 0;
    // Vector read kind beside the flags it should leave
    row_t rows [5] = '{'{2'h3, 16'h0000, 16'hB777}, '{2'h3, 16'h1000, 16'h0033},
        '{2'h3, 16'h2000, 16'hB766}, '{2'h0, 16'h2000, 16'hB722},
        '{2'h0, 16'h1000, 16'h0077}};
    power_event_flags u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events), .io_supply_fail(io_supply_fail),
        .reset_vector_read(rvr), .int_vector_read(ivr), .power_up_init(pu),
        .power_up_flags(pu_flags), .core_supply_low(core_low), .io_supply_low(io_low),
        .power_on_reset_req(por), .irq(irq));
    // Clock
    initial forever #10 pclk = ~pclk;
    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One bus transfer; a stuck slave ends the run
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // One-cycle pulse of supply fail, power-up, vector reads and events
    task automatic pulse(logic [15:0] v);
        @(posedge pclk);
        {io_supply_fail, pu, ivr, rvr, events} <= v;
        @(posedge pclk);
        {io_supply_fail, pu, ivr, rvr, events} <= 16'h0000;
    endtask : pulse
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, FLAGS_OFFSET, 0);
        chk("flags", rd, 0);
        apb(0, CTRL_OFFSET, 0);
        chk("ctrl", rd, 3);
        foreach (rows[k]) begin
            apb(1, CTRL_OFFSET, {30'h0, rows[k].ctrl});
            apb(1, FLAGS_OFFSET, 0);
            pulse(16'h0FFF);
            pulse(rows[k].vec);
            apb(0, FLAGS_OFFSET, 0);
            chk("flags", rd, {16'h0, rows[k].exp});
            $display("row %0d done", k);
        end
        apb(1, FLAGS_OFFSET, 32'hFFFFFFFF);
        apb(0, FLAGS_OFFSET, 0);
        chk("written", rd, 32'hB777);
        pulse(16'h8000);
        apb(0, FLAGS_OFFSET, 0);
        chk("supply fail", rd, 32'h3777);
        pu_flags <= 16'hFFFF;
        pulse(16'h4000);
        apb(0, FLAGS_OFFSET, 0);
        chk("power up", rd, 32'h3044);
        apb(1, MASK_OFFSET, 1);
        apb(1, FLAGS_OFFSET, 0);
        pulse(16'h0001);
        apb(0, MASK_OFFSET, 0);
        chk("irq set", irq, 1);
        apb(1, FLAGS_OFFSET, 0);
        chk("irq clear", irq, 0);
        apb(1, CTRL_OFFSET, 2);
        io_low <= 1'b1;
        apb(0, CTRL_OFFSET, 0);
        chk("por io", por, 1);
        {io_low, core_low} <= 2'b01;
        apb(0, CTRL_OFFSET, 0);
        chk("por off", por, 0);
        apb(1, CTRL_OFFSET, 1);
        apb(0, CTRL_OFFSET, 0);
        chk("por core", por, 1);
        apb(0, 12'h00C, 0);
        chk("unmapped", rd, 0);
        chk("slverr", er, 1);
        $display("hand tests done");
        conclude();
    end
endmodule : power_event_flags_tb
